// file: dofm_fault_mask.sv
// fault masking core: mask registers, summary flags, alarm pin and interrupt
// ==========================================
// Operation
// - bit 15 blocks section one crc flag
// - bit 14 blocks section two crc flag
// - bit 13 blocks section three crc flag
// - bit 11 blocks memory image crc flag
// - mask zero passes, mask one blocks
// - logic mask bit 12 reads zero
// - logic mask bits 10..0 read zero
// - overcurrent mask bits 15..4 read zero
// - bit 3 blocks converter a high flag
// - bit 2 blocks converter a low flag
// - bit 1 blocks converter b high flag
// - bit 0 blocks converter b low flag
// - overcurrent mask at 4Ah, resets zero
// - pin mask at 4Bh, resets 0780h
// - pin mask bit blocks summary on pin
`timescale 1ns/1ps
module dofm_fault_mask
   import dofm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic section_one_crc_error_flag,
   input wire logic section_two_crc_error_flag,
   input wire logic section_three_crc_error_flag,
   input wire logic memory_image_crc_error_flag,
   input wire logic conv_a_high_limit_flag,
   input wire logic conv_a_low_limit_flag,
   input wire logic conv_b_high_limit_flag,
   input wire logic conv_b_low_limit_flag,
   input wire logic alarm_pin_enable,
   output logic logic_integrity_summary_flag,
   output logic overcurrent_summary_flag,
   output logic alarm_pin_n_out,
   output logic alarm_pin_oe,
   output logic irq
);
   // ==========================================
   // input synchronisation
   dofm_sync_if flags_if ();
   logic [1:0] pin_en_sync_q;
   logic [1:0] pin_en_sync_d;

   dofm_flag_sync #(
      .WIDTH(8)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .raw_n({section_one_crc_error_flag, section_two_crc_error_flag, section_three_crc_error_flag,
              memory_image_crc_error_flag, conv_a_high_limit_flag, conv_a_low_limit_flag,
              conv_b_high_limit_flag, conv_b_low_limit_flag}),
      .flags(flags_if.source)
   );

   // ==========================================
   // registers
   logic [15:0] logic_integrity_flag_mask_q;
   logic [15:0] logic_integrity_flag_mask_d;
   logic [15:0] overcurrent_flag_mask_q;
   logic [15:0] overcurrent_flag_mask_d;
   logic [15:0] alarm_pin_mask_q;
   logic [15:0] alarm_pin_mask_d;
   logic [1:0] irq_status_q;
   logic [1:0] irq_status_d;
   logic [1:0] irq_mask_q;
   logic [1:0] irq_mask_d;
   logic [1:0] sum_prev_q;
   logic [1:0] sum_prev_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic summary_logic_n_q;
   logic summary_logic_n_d;
   logic summary_oc_n_q;
   logic summary_oc_n_d;
   logic alarm_n_q;
   logic alarm_n_d;
   logic alarm_oe_q;
   logic alarm_oe_d;

   logic [3:0] logic_pass;
   logic [3:0] oc_pass;
   logic [1:0] sum_active;
   logic [1:0] sum_rise;
   logic wr_logic;
   logic wr_oc;
   logic wr_pin;
   logic wr_irq_status;
   logic wr_irq_mask;

   always_comb begin
      wr_logic = reg_wr && (reg_addr == DOFM_LOGIC_MASK_ADDR);
      wr_oc = reg_wr && (reg_addr == DOFM_OC_MASK_ADDR);
      wr_pin = reg_wr && (reg_addr == DOFM_PIN_MASK_ADDR);
      wr_irq_status = reg_wr && (reg_addr == DOFM_IRQ_STATUS_ADDR);
      wr_irq_mask = reg_wr && (reg_addr == DOFM_IRQ_MASK_ADDR);
   end

   // ==========================================
   // masking: a flag passes when low and its mask bit is zero
   always_comb begin
      logic_pass[3] = !flags_if.logic_flags_n[3] && !logic_integrity_flag_mask_q[DOFM_SEC1_BIT];
      logic_pass[2] = !flags_if.logic_flags_n[2] && !logic_integrity_flag_mask_q[DOFM_SEC2_BIT];
      logic_pass[1] = !flags_if.logic_flags_n[1] && !logic_integrity_flag_mask_q[DOFM_SEC3_BIT];
      logic_pass[0] = !flags_if.logic_flags_n[0] && !logic_integrity_flag_mask_q[DOFM_MEMIMG_BIT];
      oc_pass[3] = !flags_if.oc_flags_n[3] && !overcurrent_flag_mask_q[DOFM_CA_HIGH_BIT];
      oc_pass[2] = !flags_if.oc_flags_n[2] && !overcurrent_flag_mask_q[DOFM_CA_LOW_BIT];
      oc_pass[1] = !flags_if.oc_flags_n[1] && !overcurrent_flag_mask_q[DOFM_CB_HIGH_BIT];
      oc_pass[0] = !flags_if.oc_flags_n[0] && !overcurrent_flag_mask_q[DOFM_CB_LOW_BIT];
      summary_logic_n_d = !(|logic_pass);
      summary_oc_n_d = !(|oc_pass);
      sum_active[DOFM_SUM_LOGIC_BIT] = !summary_logic_n_q;
      sum_active[DOFM_SUM_OC_BIT] = !summary_oc_n_q;
      // pin follows an active summary unless its pin mask bit is set
      alarm_n_d = !((sum_active[DOFM_SUM_LOGIC_BIT] && !alarm_pin_mask_q[DOFM_PIN_LOGIC_BIT])
                    || (sum_active[DOFM_SUM_OC_BIT] && !alarm_pin_mask_q[DOFM_PIN_OC_BIT]));
      alarm_oe_d = pin_en_sync_q[1];
      pin_en_sync_d = {pin_en_sync_q[0], alarm_pin_enable};
   end

   // ==========================================
   // register writes; reserved bits stay zero
   always_comb begin
      logic_integrity_flag_mask_d = logic_integrity_flag_mask_q;
      overcurrent_flag_mask_d = overcurrent_flag_mask_q;
      alarm_pin_mask_d = alarm_pin_mask_q;
      irq_mask_d = irq_mask_q;
      if (wr_logic) begin
         logic_integrity_flag_mask_d = reg_wdata & DOFM_LOGIC_MASK_WMASK;
      end
      if (wr_oc) begin
         overcurrent_flag_mask_d = reg_wdata & DOFM_OC_MASK_WMASK;
      end
      if (wr_pin) begin
         alarm_pin_mask_d = reg_wdata & DOFM_PIN_MASK_WMASK;
      end
      if (wr_irq_mask) begin
         irq_mask_d = reg_wdata[1:0];
      end
   end

   // ==========================================
   // interrupt: summary assertion sets sticky bit, set beats write-one-clear
   always_comb begin
      sum_prev_d = sum_active;
      sum_rise = sum_active & ~sum_prev_q;
      irq_status_d = irq_status_q;
      if (wr_irq_status) begin
         irq_status_d = irq_status_q & ~reg_wdata[1:0];
      end
      irq_status_d = irq_status_d | sum_rise;
   end

   // ==========================================
   // read data, one cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            DOFM_LOGIC_MASK_ADDR: rdata_d = logic_integrity_flag_mask_q;
            DOFM_OC_MASK_ADDR: rdata_d = overcurrent_flag_mask_q;
            DOFM_PIN_MASK_ADDR: rdata_d = alarm_pin_mask_q;
            DOFM_SUMMARY_ADDR: rdata_d = {14'h0000, summary_logic_n_q, summary_oc_n_q};
            DOFM_IRQ_STATUS_ADDR: rdata_d = {14'h0000, irq_status_q};
            DOFM_IRQ_MASK_ADDR: rdata_d = {14'h0000, irq_mask_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         logic_integrity_flag_mask_q <= DOFM_LOGIC_MASK_RST;
         overcurrent_flag_mask_q <= DOFM_OC_MASK_RST;
         alarm_pin_mask_q <= DOFM_PIN_MASK_RST;
         irq_status_q <= 2'h0;
         irq_mask_q <= DOFM_IRQ_MASK_RST[1:0];
         sum_prev_q <= 2'h0;
         rdata_q <= 16'h0000;
         summary_logic_n_q <= 1'b1;
         summary_oc_n_q <= 1'b1;
         alarm_n_q <= 1'b1;
         alarm_oe_q <= 1'b0;
         pin_en_sync_q <= 2'h0;
      end else begin
         logic_integrity_flag_mask_q <= logic_integrity_flag_mask_d;
         overcurrent_flag_mask_q <= overcurrent_flag_mask_d;
         alarm_pin_mask_q <= alarm_pin_mask_d;
         irq_status_q <= irq_status_d;
         irq_mask_q <= irq_mask_d;
         sum_prev_q <= sum_prev_d;
         rdata_q <= rdata_d;
         summary_logic_n_q <= summary_logic_n_d;
         summary_oc_n_q <= summary_oc_n_d;
         alarm_n_q <= alarm_n_d;
         alarm_oe_q <= alarm_oe_d;
         pin_en_sync_q <= pin_en_sync_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign logic_integrity_summary_flag = summary_logic_n_q;
   assign overcurrent_summary_flag = summary_oc_n_q;
   assign alarm_pin_n_out = alarm_n_q;
   assign alarm_pin_oe = alarm_oe_q;
   assign irq = |(irq_status_q & ~irq_mask_q);

   // ==========================================
   // checks
   sequence s_logic_any_fault;
      (logic_integrity_flag_mask_q == 16'h0000) && !(&flags_if.logic_flags_n);
   endsequence

   sequence s_logic_pass_any;
      (|logic_pass);
   endsequence

   sequence s_oc_pass_any;
      (|oc_pass);
   endsequence

   sequence s_logic_first_pass;
      (|logic_pass) && summary_logic_n_q;
   endsequence

   sequence s_logic_flag_then_sticky;
      !summary_logic_n_q ##1 irq_status_q[DOFM_SUM_LOGIC_BIT];
   endsequence

   sequence s_oc_first_pass;
      (|oc_pass) && summary_oc_n_q;
   endsequence

   sequence s_oc_flag_then_sticky;
      !summary_oc_n_q ##1 irq_status_q[DOFM_SUM_OC_BIT];
   endsequence

   sequence s_pin_sees_logic;
      !summary_logic_n_q && !alarm_pin_mask_q[DOFM_PIN_LOGIC_BIT];
   endsequence

   sequence s_pin_sees_oc;
      !summary_oc_n_q && !alarm_pin_mask_q[DOFM_PIN_OC_BIT];
   endsequence

   chk_sec1_mask_block: assert property (@(posedge core_clk) disable iff (rst)
      (logic_integrity_flag_mask_q == 16'h8000 && flags_if.logic_flags_n == 4'h7) |=> summary_logic_n_q)
      else $error("section one flag passed while masked");
   chk_sec2_mask_block: assert property (@(posedge core_clk) disable iff (rst)
      (logic_integrity_flag_mask_q == 16'h4000 && flags_if.logic_flags_n == 4'hb) |=> summary_logic_n_q)
      else $error("section two flag passed while masked");
   chk_sec3_mask_block: assert property (@(posedge core_clk) disable iff (rst)
      (logic_integrity_flag_mask_q == 16'h2000 && flags_if.logic_flags_n == 4'hd) |=> summary_logic_n_q)
      else $error("section three flag passed while masked");
   chk_memimg_mask_block: assert property (@(posedge core_clk) disable iff (rst)
      (logic_integrity_flag_mask_q == 16'h0800 && flags_if.logic_flags_n == 4'he) |=> summary_logic_n_q)
      else $error("memory image flag passed while masked");
   chk_unmasked_passes: assert property (@(posedge core_clk) disable iff (rst)
      s_logic_any_fault |=> !summary_logic_n_q)
      else $error("unmasked flag failed to assert summary");
   chk_logic_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
      $past(reg_rd) && $past(reg_addr) == DOFM_LOGIC_MASK_ADDR |-> reg_rdata[12] == 1'b0 && reg_rdata[10:0] == 11'h000)
      else $error("reserved logic mask bits read nonzero");
   chk_logic_bit12_zero: assert property (@(posedge core_clk) disable iff (rst)
      logic_integrity_flag_mask_q[12] == 1'b0)
      else $error("logic mask bit 12 held nonzero");
   chk_logic_low_zero: assert property (@(posedge core_clk) disable iff (rst)
      logic_integrity_flag_mask_q[10:0] == 11'h000)
      else $error("logic mask low bits held nonzero");
   chk_oc_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
      $past(reg_rd) && $past(reg_addr) == DOFM_OC_MASK_ADDR |-> reg_rdata[15:4] == 12'h000)
      else $error("reserved overcurrent mask bits read nonzero");
   chk_oc_high_zero: assert property (@(posedge core_clk) disable iff (rst)
      overcurrent_flag_mask_q[15:4] == 12'h000)
      else $error("overcurrent mask upper bits held nonzero");
   chk_ca_high_block: assert property (@(posedge core_clk) disable iff (rst)
      (overcurrent_flag_mask_q == 16'h0008 && flags_if.oc_flags_n == 4'h7) |=> summary_oc_n_q)
      else $error("converter a high flag passed while masked");
   chk_ca_low_block: assert property (@(posedge core_clk) disable iff (rst)
      (overcurrent_flag_mask_q == 16'h0004 && flags_if.oc_flags_n == 4'hb) |=> summary_oc_n_q)
      else $error("converter a low flag passed while masked");
   chk_cb_high_block: assert property (@(posedge core_clk) disable iff (rst)
      (overcurrent_flag_mask_q == 16'h0002 && flags_if.oc_flags_n == 4'hd) |=> summary_oc_n_q)
      else $error("converter b high flag passed while masked");
   chk_cb_low_block: assert property (@(posedge core_clk) disable iff (rst)
      (overcurrent_flag_mask_q == 16'h0001 && flags_if.oc_flags_n == 4'he) |=> summary_oc_n_q)
      else $error("converter b low flag passed while masked");
   chk_oc_reset_value: assert property (@(posedge core_clk)
      $past(rst) |-> overcurrent_flag_mask_q == 16'h0000)
      else $error("overcurrent mask not zero after reset");
   chk_pin_reset_value: assert property (@(posedge core_clk)
      $past(rst) |-> alarm_pin_mask_q == 16'h0780)
      else $error("pin mask reset value wrong");
   chk_pin_masked_quiet: assert property (@(posedge core_clk) disable iff (rst)
      (alarm_pin_mask_q[12:11] == 2'b11) |=> alarm_pin_n_out)
      else $error("alarm pin driven by masked summaries");
   chk_pin_follows_logic: assert property (@(posedge core_clk) disable iff (rst)
      s_pin_sees_logic |=> !alarm_pin_n_out)
      else $error("alarm pin missed unmasked logic summary");
   chk_pin_follows_oc: assert property (@(posedge core_clk) disable iff (rst)
      s_pin_sees_oc |=> !alarm_pin_n_out)
      else $error("alarm pin missed unmasked overcurrent summary");
   chk_pin_quiet_idle: assert property (@(posedge core_clk) disable iff (rst)
      (summary_logic_n_q && summary_oc_n_q) |=> alarm_pin_n_out)
      else $error("alarm pin driven with no active summary");
   chk_oc_summary_any: assert property (@(posedge core_clk) disable iff (rst)
      s_oc_pass_any |=> !summary_oc_n_q)
      else $error("overcurrent summary did not assert");
   chk_oc_summary_idle: assert property (@(posedge core_clk) disable iff (rst)
      !(|oc_pass) |=> summary_oc_n_q)
      else $error("overcurrent summary asserted with no unmasked flag");
   chk_logic_summary_any: assert property (@(posedge core_clk) disable iff (rst)
      s_logic_pass_any |=> !summary_logic_n_q)
      else $error("logic summary did not assert");
   chk_logic_summary_idle: assert property (@(posedge core_clk) disable iff (rst)
      !(|logic_pass) |=> summary_logic_n_q)
      else $error("logic summary asserted with no unmasked flag");
   chk_oc_sticky_set: assert property (@(posedge core_clk) disable iff (rst)
      s_oc_first_pass |=> s_oc_flag_then_sticky)
      else $error("overcurrent status bit not set on summary assertion");
   chk_logic_sticky_set: assert property (@(posedge core_clk) disable iff (rst)
      s_logic_first_pass |=> s_logic_flag_then_sticky)
      else $error("logic status bit not set on summary assertion");
   chk_oc_status_clear: assert property (@(posedge core_clk) disable iff (rst)
      (wr_irq_status && reg_wdata[DOFM_SUM_OC_BIT] && !sum_rise[DOFM_SUM_OC_BIT]) |=> !irq_status_q[DOFM_SUM_OC_BIT])
      else $error("overcurrent status bit not cleared by write");
   chk_logic_status_clear: assert property (@(posedge core_clk) disable iff (rst)
      (wr_irq_status && reg_wdata[DOFM_SUM_LOGIC_BIT] && !sum_rise[DOFM_SUM_LOGIC_BIT])
      |=> !irq_status_q[DOFM_SUM_LOGIC_BIT])
      else $error("logic status bit not cleared by write");
   chk_rdata_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
      !$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data present without a read");
   chk_reset_outputs: assert property (@(posedge core_clk)
      $past(rst) |-> (reg_rdata == 16'h0000 && summary_logic_n_q && summary_oc_n_q
                       && alarm_pin_n_out && !alarm_pin_oe && !irq))
      else $error("outputs not idle after reset");
   chk_oe_follows_enable: assert property (@(posedge core_clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)) |-> alarm_pin_oe == $past(alarm_pin_enable, 3))
      else $error("alarm pin enable not followed");
endmodule // dofm_fault_mask

// file: dofm_pkg.sv
// package of register offsets, field positions and reset values for the fault-masking block
package dofm_pkg;
   localparam int unsigned DOFM_ADDR_W = 8;
   localparam int unsigned DOFM_DATA_W = 16;
   // register offsets
   localparam logic [7:0] DOFM_LOGIC_MASK_ADDR = 8'h49;
   localparam logic [7:0] DOFM_OC_MASK_ADDR = 8'h4a;
   localparam logic [7:0] DOFM_PIN_MASK_ADDR = 8'h4b;
   localparam logic [7:0] DOFM_SUMMARY_ADDR = 8'h50;
   localparam logic [7:0] DOFM_IRQ_STATUS_ADDR = 8'h51;
   localparam logic [7:0] DOFM_IRQ_MASK_ADDR = 8'h52;
   // reset values
   localparam logic [15:0] DOFM_LOGIC_MASK_RST = 16'h0000;
   localparam logic [15:0] DOFM_OC_MASK_RST = 16'h0000;
   localparam logic [15:0] DOFM_PIN_MASK_RST = 16'h0780;
   localparam logic [15:0] DOFM_IRQ_MASK_RST = 16'h0000;
   // writable bits of each mask register
   localparam logic [15:0] DOFM_LOGIC_MASK_WMASK = 16'he800;
   localparam logic [15:0] DOFM_OC_MASK_WMASK = 16'h000f;
   localparam logic [15:0] DOFM_PIN_MASK_WMASK = 16'h7f80;
   // logic integrity mask fields
   localparam int unsigned DOFM_SEC1_BIT = 15;
   localparam int unsigned DOFM_SEC2_BIT = 14;
   localparam int unsigned DOFM_SEC3_BIT = 13;
   localparam int unsigned DOFM_MEMIMG_BIT = 11;
   // overcurrent mask fields
   localparam int unsigned DOFM_CA_HIGH_BIT = 3;
   localparam int unsigned DOFM_CA_LOW_BIT = 2;
   localparam int unsigned DOFM_CB_HIGH_BIT = 1;
   localparam int unsigned DOFM_CB_LOW_BIT = 0;
   // alarm pin mask fields (summary flags the pin may follow)
   localparam int unsigned DOFM_PIN_LOGIC_BIT = 12;
   localparam int unsigned DOFM_PIN_OC_BIT = 11;
   // summary / interrupt status layout
   localparam int unsigned DOFM_SUM_LOGIC_BIT = 1;
   localparam int unsigned DOFM_SUM_OC_BIT = 0;
   localparam int unsigned DOFM_NUM_SUM = 2;
endpackage

// file: dofm_sync_if.sv
// interface carrying the synchronised fault flags between the synchroniser and the masking core
`timescale 1ns/1ps
interface dofm_sync_if;
   logic [3:0] logic_flags_n;
   logic [3:0] oc_flags_n;
   modport source (output logic_flags_n, output oc_flags_n);
   modport sink (input logic_flags_n, input oc_flags_n);
endinterface

// file: dofm_flag_sync.sv
// two-stage synchroniser for the active-low fault flag inputs
`timescale 1ns/1ps
module dofm_flag_sync
   import dofm_pkg::*;
#(
   parameter int unsigned WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] raw_n,
   dofm_sync_if.source flags
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = raw_n;
      sync_d = meta_q;
   end

   // flags are inactive (high) under reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign flags.logic_flags_n = sync_q[7:4];
   assign flags.oc_flags_n = sync_q[3:0];
endmodule // dofm_flag_sync

// file: dofm_fault_mask_bench.sv
// self-checking testbench for the fault-masking core
`timescale 1ns/1ps
module dofm_fault_mask_bench;
   import dofm_pkg::*;
   logic core_clk;
   logic rst;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [3:0] lg_n;
   logic [3:0] oc_n;
   logic pin_en;
   logic lg_sum;
   logic oc_sum;
   logic pin_n;
   logic pin_oe;
   logic irq;
   int bad_count;
   int samples_checked;
   int lg_bit[4] = '{15, 14, 13, 11};
   int oc_bit[4] = '{3, 2, 1, 0};

   // ==========================================
   // design under test
   dofm_fault_mask uut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .section_one_crc_error_flag(lg_n[0]),
      .section_two_crc_error_flag(lg_n[1]),
      .section_three_crc_error_flag(lg_n[2]),
      .memory_image_crc_error_flag(lg_n[3]),
      .conv_a_high_limit_flag(oc_n[0]),
      .conv_a_low_limit_flag(oc_n[1]),
      .conv_b_high_limit_flag(oc_n[2]),
      .conv_b_low_limit_flag(oc_n[3]),
      .alarm_pin_enable(pin_en),
      .logic_integrity_summary_flag(lg_sum),
      .overcurrent_summary_flag(oc_sum),
      .alarm_pin_n_out(pin_n),
      .alarm_pin_oe(pin_oe),
      .irq(irq)
   );

   // ==========================================
   // clock, tasks
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   function automatic logic [15:0] bit_of(input int b);
      return 16'(32'd1 << b);
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // both summary flags once the flag pipeline has settled
   task automatic see(input logic e_lg, input logic e_oc);
      repeat (5) @(posedge core_clk);
      #1;
      chk({14'h0000, lg_sum, oc_sum}, {14'h0000, e_lg, e_oc});
   endtask

   task automatic pin_irq(input logic e_oe, input logic e_pin, input logic e_irq);
      repeat (5) @(posedge core_clk);
      #1;
      chk({13'h0000, pin_oe, pin_n, irq}, {13'h0000, e_oe, e_pin, e_irq});
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #40000;
      bad_count++;
      end_sim();
   end

   // ==========================================
   // tests
   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      lg_n = 4'hf;
      oc_n = 4'hf;
      pin_en = 1'b1;
      bad_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(DOFM_OC_MASK_ADDR, 16'h0000);
      rd(DOFM_PIN_MASK_ADDR, 16'h0780);
      rd(DOFM_LOGIC_MASK_ADDR, 16'h0000);
      rd(DOFM_SUMMARY_ADDR, 16'h0003);
      rd(DOFM_IRQ_MASK_ADDR, 16'h0000);
      rd(8'h7f, 16'h0000);
      see(1'b1, 1'b1);
      $display("test reset values done");
      wr(DOFM_LOGIC_MASK_ADDR, 16'hffff);
      rd(DOFM_LOGIC_MASK_ADDR, 16'he800);
      wr(DOFM_OC_MASK_ADDR, 16'hffff);
      rd(DOFM_OC_MASK_ADDR, 16'h000f);
      wr(DOFM_PIN_MASK_ADDR, 16'hffff);
      rd(DOFM_PIN_MASK_ADDR, 16'h7f80);
      wr(8'h7f, 16'hffff);
      rd(8'h7f, 16'h0000);
      wr(DOFM_LOGIC_MASK_ADDR, 16'h0000);
      wr(DOFM_OC_MASK_ADDR, 16'h0000);
      wr(DOFM_PIN_MASK_ADDR, 16'h0780);
      $display("test reserved bits done");
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         lg_n[i] <= 1'b0;
         see(1'b0, 1'b1);
         wr(DOFM_LOGIC_MASK_ADDR, DOFM_LOGIC_MASK_WMASK & ~bit_of(lg_bit[i]));
         see(1'b0, 1'b1);
         wr(DOFM_LOGIC_MASK_ADDR, bit_of(lg_bit[i]));
         see(1'b1, 1'b1);
         @(posedge core_clk);
         lg_n[i] <= 1'b1;
         wr(DOFM_LOGIC_MASK_ADDR, 16'h0000);
         see(1'b1, 1'b1);
      end
      $display("test logic masking done");
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         oc_n[i] <= 1'b0;
         see(1'b1, 1'b0);
         wr(DOFM_OC_MASK_ADDR, 16'h000f & ~bit_of(oc_bit[i]));
         see(1'b1, 1'b0);
         wr(DOFM_OC_MASK_ADDR, bit_of(oc_bit[i]));
         see(1'b1, 1'b1);
         @(posedge core_clk);
         oc_n[i] <= 1'b1;
         wr(DOFM_OC_MASK_ADDR, 16'h0000);
      end
      $display("test overcurrent masking done");
      wr(DOFM_IRQ_STATUS_ADDR, 16'h0003);
      rd(DOFM_IRQ_STATUS_ADDR, 16'h0000);
      pin_irq(1'b1, 1'b1, 1'b0);
      @(posedge core_clk);
      oc_n[2] <= 1'b0;
      pin_irq(1'b1, 1'b0, 1'b1);
      rd(DOFM_IRQ_STATUS_ADDR, 16'h0001);
      wr(DOFM_PIN_MASK_ADDR, 16'h0800);
      wr(DOFM_IRQ_MASK_ADDR, 16'h0001);
      rd(DOFM_IRQ_MASK_ADDR, 16'h0001);
      pin_irq(1'b1, 1'b1, 1'b0);
      @(posedge core_clk);
      oc_n[2] <= 1'b1;
      lg_n[3] <= 1'b0;
      pin_irq(1'b1, 1'b0, 1'b1);
      rd(DOFM_IRQ_STATUS_ADDR, 16'h0003);
      rd(DOFM_SUMMARY_ADDR, 16'h0001);
      wr(DOFM_PIN_MASK_ADDR, 16'h1800);
      pin_irq(1'b1, 1'b1, 1'b1);
      @(posedge core_clk);
      lg_n[3] <= 1'b1;
      pin_en <= 1'b0;
      wr(DOFM_IRQ_STATUS_ADDR, 16'h0002);
      pin_irq(1'b0, 1'b1, 1'b0);
      rd(DOFM_IRQ_STATUS_ADDR, 16'h0001);
      wr(DOFM_IRQ_STATUS_ADDR, 16'h0001);
      wr(DOFM_IRQ_MASK_ADDR, 16'h0000);
      pin_irq(1'b0, 1'b1, 1'b0);
      rd(DOFM_IRQ_STATUS_ADDR, 16'h0000);
      $display("test alarm pin and interrupt done");
      wr(DOFM_OC_MASK_ADDR, 16'h0005);
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      rd(DOFM_OC_MASK_ADDR, 16'h0000);
      rd(DOFM_PIN_MASK_ADDR, 16'h0780);
      $display("test second reset done");
      end_sim();
   end
endmodule // dofm_fault_mask_bench
